/* inc/grm_pkg.sv */
// Shared constants for the glyph RAM controller: register map, command
// classes, field positions, reset values and timing counts.
// Assumes one 250 MHz hclk that also stands in for the oscillator cycle.
package grm_pkg;

   // Register byte addresses on the AHB-Lite slave
   localparam int ADDR_W = 8;
   localparam logic [ADDR_W-1:0] REG_INSTR = 8'h00;
   localparam logic [ADDR_W-1:0] REG_DATA = 8'h04;
   localparam logic [ADDR_W-1:0] REG_STATUS = 8'h08;
   localparam logic [ADDR_W-1:0] REG_CONFIG = 8'h0C;
   localparam logic [ADDR_W-1:0] REG_PXSEL = 8'h10;
   localparam logic [ADDR_W-1:0] REG_PXROW = 8'h14;
   localparam logic [2:0] HSIZE_WORD = 3'h2;

   // RAM geometry
   localparam int GR_AW = 7;
   localparam int GR_DW = 8;
   localparam int GR_COLS = 5;
   localparam int ROW_W = 3;
   localparam int DD_AW = 7;
   localparam int DD_DEPTH = 128;
   localparam int CODE_CG_LSB = 4;
   localparam logic [ROW_W-1:0] CURSOR_ROW = 3'h7;
   localparam logic [7:0] SPACE_CODE = 8'h20;
   localparam logic [DD_AW-1:0] DD_END_1LINE = 7'h50;
   localparam logic [DD_AW-2:0] DD_END_2LINE = 6'h28;

   // Instruction field positions
   localparam int ID_BIT = 1;
   localparam int SH_BIT = 0;
   localparam int D_BIT = 2;
   localparam int C_BIT = 1;
   localparam int B_BIT = 0;
   localparam int DL_BIT = 4;
   localparam int M_BIT = 2;
   localparam int SL_BIT = 1;
   localparam int H_BIT = 0;

   // Values after reset
   localparam logic RST_ID = 1'h1;
   localparam logic RST_SHIFT = 1'h0;
   localparam logic RST_DISP = 1'h0;
   localparam logic RST_CUR = 1'h0;
   localparam logic RST_BLINK = 1'h0;
   localparam logic RST_DL = 1'h1;
   localparam logic RST_LINES = 1'h0;
   localparam logic RST_PAGE = 1'h0;
   localparam logic RST_SL = 1'h0;
   localparam logic [1:0] RST_ICON = 2'h0;
   localparam logic [2:0] RST_SCREEN = 3'h0;
   localparam logic [1:0] RST_TEMPCO = 2'h0;
   localparam logic [1:0] RST_VGEN = 2'h0;
   localparam logic [1:0] RST_PUMP = 2'h2;

   // Timing
   localparam int CLK_PERIOD_NS = 4;
   localparam int CLK_PER_OSC = 1;
   localparam int CLEAR_OSC_CYC = 165;
   localparam int EXEC_OSC_CYC = 3;
   localparam int CLEAR_CYC = CLEAR_OSC_CYC * CLK_PER_OSC;
   localparam int EXEC_CYC = EXEC_OSC_CYC * CLK_PER_OSC;
   localparam int INIT_TIME_NS = 2000000;
   localparam int INIT_CYC = (INIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   typedef enum logic [1:0] {
      ST_CLEAR = 2'h0,
      ST_INIT = 2'h1,
      ST_IDLE = 2'h3,
      ST_EXEC = 2'h2
   } grm_state_e;

   // Class of an instruction byte is the position of its leading one plus one
   typedef enum logic [3:0] {
      CMD_NOP = 4'h0,
      CMD_CLEAR = 4'h1,
      CMD_HOME = 4'h2,
      CMD_ENTRY = 4'h3,
      CMD_DISP = 4'h4,
      CMD_SHIFT = 4'h5,
      CMD_FUNC = 4'h6,
      CMD_SETCG = 4'h7,
      CMD_SETDD = 4'h8
   } grm_cmd_e;

   typedef enum logic [1:0] {
      SER_IDLE = 2'h0,
      SER_ADDR = 2'h1,
      SER_CTRL = 2'h3,
      SER_DATA = 2'h2
   } grm_ser_e;

   typedef struct packed {
      logic cur;
      logic [ROW_W-1:0] row;
      logic [7:0] code;
   } grm_pxsel_s;

endpackage

/* verilog/grm_glyph_ram.sv */
// Glyph pattern RAM with a host port and a pattern-row fetch port.
// Assumes writes come from the controller; reads are combinational.
`timescale 1ns/1ps
`default_nettype none
module grm_glyph_ram #(
   parameter int AW = grm_pkg::GR_AW,
   parameter int DW = grm_pkg::GR_DW,
   parameter int COLS = grm_pkg::GR_COLS
) (
   input wire logic clk, // Clock
   input wire logic rst_n, // Reset, checks only
   input wire logic wr_en, // Write strobe
   input wire logic [AW-1:0] wr_addr, // Write address
   input wire logic [DW-1:0] wr_data, // Write data
   input wire logic [AW-1:0] rd_addr, // Host read address
   output logic [DW-1:0] rd_data, // Host read data
   input wire logic [7:0] code, // Character code
   input wire logic [grm_pkg::ROW_W-1:0] row, // Pattern row
   input wire logic cursor_here, // Cursor shown on this character
   output logic [COLS-1:0] pixels, // Lit columns of the row
   output logic hit // Code selects glyph RAM
);
   logic [DW-1:0] glyph_pattern_ram [2**AW];
   logic [AW-1:0] px_addr;
   logic [DW-1:0] px_word;

   // Storage, no reset: contents are undefined until software loads them
   always_ff @(posedge clk) begin
      if (wr_en) begin
         glyph_pattern_ram[wr_addr] <= wr_data;
      end
   end

   // Row fetch; non-glyph codes give a dark row since the ROM lies elsewhere
   always_comb begin
      hit = (code[7:grm_pkg::CODE_CG_LSB] == '0);
      px_addr = {code[AW-grm_pkg::ROW_W-1:0], row};
      px_word = glyph_pattern_ram[px_addr];
      rd_data = glyph_pattern_ram[rd_addr];
      pixels = '0;
      if (hit) begin
         pixels = px_word[COLS-1:0];
         if (row == grm_pkg::CURSOR_ROW && cursor_here) begin
            pixels = '1;
         end
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   row_index_a: assert property (px_addr[grm_pkg::ROW_W-1:0] == row)
      else $error("pattern row index not taken from row");
   cursor_or_a: assert property ((hit && cursor_here && row == grm_pkg::CURSOR_ROW) |-> pixels == '1)
      else $error("cursor row not ORed with cursor");
   col_mask_a: assert property ((hit && row != grm_pkg::CURSOR_ROW) |-> pixels == px_word[COLS-1:0])
      else $error("columns not taken from low data bits");
   glyph_sel_a: assert property (hit == (code[7:grm_pkg::CODE_CG_LSB] == '0))
      else $error("glyph RAM selection wrong");
   dark_rom_a: assert property ((!hit || px_word[COLS-1:0] == '0) && !cursor_here |-> pixels == '0)
      else $error("pixel lit without a one bit");

endmodule
`default_nettype wire

/* verilog/grm_glyph_ctrl.sv */
// Character controller core: AHB-Lite register slave, instruction decode,
// address counter, character code RAM, reset initialisation.
// Assumes a single hclk domain and a master doing single word transfers.
//
// The AHB-Lite slave port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module grm_glyph_ctrl #(
   parameter int INIT_CYCLES = grm_pkg::INIT_CYC // Busy length after reset
) (
   input wire logic hclk, // Clock
   input wire logic hresetn, // Async reset, low
   input wire logic hsel, // Slave select
   input wire logic [grm_pkg::ADDR_W-1:0] haddr, // Byte address
   input wire logic [1:0] htrans, // Transfer type
   input wire logic hwrite, // Write when high
   input wire logic [2:0] hsize, // Transfer size
   input wire logic hready, // Bus ready
   input wire logic [31:0] hwdata, // Write data
   output logic [31:0] hrdata, // Read data
   output logic hreadyout, // Slave ready
   output logic hresp, // Always OKAY
   output logic busy_indicator, // Busy, high
   output logic display_enable // Display on
);
   localparam int CW = $clog2(INIT_CYCLES);
   localparam int AW = grm_pkg::GR_AW;
   localparam logic [CW-1:0] CLEAR_LAST = CW'(grm_pkg::CLEAR_CYC - 1);
   localparam logic [CW-1:0] EXEC_LAST = CW'(grm_pkg::EXEC_CYC - 1);
   localparam logic [CW-1:0] INIT_LAST = CW'(INIT_CYCLES - grm_pkg::CLEAR_CYC - 1);
   localparam logic [CW-1:0] DD_DEPTH_CNT = CW'(grm_pkg::DD_DEPTH);

   grm_pkg::grm_state_e state_r, state_nxt;
   grm_pkg::grm_cmd_e cmd_cls;
   grm_pkg::grm_ser_e ser_state_r;
   grm_pkg::grm_pxsel_s px_sel_r;
   logic [CW-1:0] cnt_r, cnt_nxt;
   logic from_rst_r;
   logic wr_pend_r, rd_pend_r, accept;
   logic [grm_pkg::ADDR_W-1:0] addr_r;
   logic [31:0] rdata_nxt;
   logic id_r, shift_r, cur_r, blink_r, dl_r, lines_r, sl_r, page_r;
   logic sel_cg_r;
   logic [AW-1:0] cg_addr_r, dd_addr_r, ac;
   logic [7:0] character_code_ram [grm_pkg::DD_DEPTH];
   logic [7:0] cmd, gl_rd_data, dread_byte;
   logic instr_go, data_go, dread_go, clear_go, px_cursor;
   logic [grm_pkg::GR_COLS-1:0] gl_pixels;
   logic gl_hit;
   logic [22:0] cfg;

   // Class of an instruction byte from its leading one
   function automatic grm_pkg::grm_cmd_e cmd_class(input logic [7:0] d);
      grm_pkg::grm_cmd_e c;
      c = grm_pkg::CMD_NOP;
      for (int i = 0; i < 8; i++) begin
         if (d[i]) begin
            c = grm_pkg::grm_cmd_e'(4'(i + 1));
         end
      end
      return c;
   endfunction

   // Auto increment or decrement; wraps so bit 6 takes the carry
   function automatic logic [AW-1:0] step_addr(input logic [AW-1:0] a, input logic inc);
      return inc ? a + 7'h01 : a - 7'h01;
   endfunction

   // Code RAM address valid for the current line mode
   function automatic logic dd_in_range(input logic [AW-1:0] a, input logic two_line);
      return two_line ? (a[AW-2:0] < grm_pkg::DD_END_2LINE) : (a < grm_pkg::DD_END_1LINE);
   endfunction

   // Command decode; instruction and data register accesses are not served while busy
   always_comb begin
      accept = hsel && hready && htrans[1];
      cmd = hwdata[7:0];
      cmd_cls = cmd_class(cmd);
      instr_go = wr_pend_r && addr_r == grm_pkg::REG_INSTR && state_r == grm_pkg::ST_IDLE;
      data_go = wr_pend_r && addr_r == grm_pkg::REG_DATA && state_r == grm_pkg::ST_IDLE;
      dread_go = rd_pend_r && addr_r == grm_pkg::REG_DATA && state_r == grm_pkg::ST_IDLE;
      clear_go = instr_go && !page_r && cmd_cls == grm_pkg::CMD_CLEAR;
      ac = sel_cg_r ? cg_addr_r : dd_addr_r;
      px_cursor = px_sel_r.cur && cur_r;
      dread_byte = sel_cg_r ? gl_rd_data : character_code_ram[dd_addr_r];
      cfg = {ser_state_r, sel_cg_r, grm_pkg::RST_PUMP, grm_pkg::RST_VGEN, grm_pkg::RST_TEMPCO,
             grm_pkg::RST_SCREEN, grm_pkg::RST_ICON, page_r, sl_r, lines_r, dl_r, blink_r, cur_r,
             display_enable, shift_r, id_r};
   end

   // Sequencer: reset clear, init hold, idle, instruction execution
   always_comb begin
      state_nxt = state_r;
      cnt_nxt = cnt_r + CW'(1);
      unique case (state_r)
         grm_pkg::ST_CLEAR: begin
            if (cnt_r == CLEAR_LAST) begin
               state_nxt = from_rst_r ? grm_pkg::ST_INIT : grm_pkg::ST_IDLE;
               cnt_nxt = '0;
            end
         end
         grm_pkg::ST_INIT: begin
            if (cnt_r == INIT_LAST) begin
               state_nxt = grm_pkg::ST_IDLE;
               cnt_nxt = '0;
            end
         end
         grm_pkg::ST_IDLE: begin
            cnt_nxt = '0;
            if (clear_go) begin
               state_nxt = grm_pkg::ST_CLEAR;
            end else if (instr_go || data_go || dread_go) begin
               state_nxt = grm_pkg::ST_EXEC;
            end
         end
         grm_pkg::ST_EXEC: begin
            if (cnt_r == EXEC_LAST) begin
               state_nxt = grm_pkg::ST_IDLE;
               cnt_nxt = '0;
            end
         end
      endcase
   end

   // Reset enters the clear step directly, so the host sees busy at once
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_r <= grm_pkg::ST_CLEAR;
         cnt_r <= '0;
         from_rst_r <= 1'h1;
         busy_indicator <= 1'h1;
      end else begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
         busy_indicator <= (state_nxt != grm_pkg::ST_IDLE);
         if (state_r == grm_pkg::ST_INIT) begin
            from_rst_r <= 1'h0;
         end
      end
   end

   // Serial front end forced idle through the reset clear step and the first init cycle
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ser_state_r <= grm_pkg::SER_IDLE;
      end else if (from_rst_r) begin
         ser_state_r <= grm_pkg::SER_IDLE;
      end
   end

   // Mode bits; extended page decodes only function set in this block
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         id_r <= grm_pkg::RST_ID;
         shift_r <= grm_pkg::RST_SHIFT;
         display_enable <= grm_pkg::RST_DISP;
         cur_r <= grm_pkg::RST_CUR;
         blink_r <= grm_pkg::RST_BLINK;
         dl_r <= grm_pkg::RST_DL;
         lines_r <= grm_pkg::RST_LINES;
         page_r <= grm_pkg::RST_PAGE;
         sl_r <= grm_pkg::RST_SL;
      end else if (instr_go) begin
         if (!page_r && cmd_cls == grm_pkg::CMD_ENTRY) begin
            id_r <= cmd[grm_pkg::ID_BIT];
            shift_r <= cmd[grm_pkg::SH_BIT];
         end
         if (!page_r && cmd_cls == grm_pkg::CMD_DISP) begin
            display_enable <= cmd[grm_pkg::D_BIT];
            cur_r <= cmd[grm_pkg::C_BIT];
            blink_r <= cmd[grm_pkg::B_BIT];
         end
         if (cmd_cls == grm_pkg::CMD_FUNC) begin
            dl_r <= cmd[grm_pkg::DL_BIT];
            lines_r <= cmd[grm_pkg::M_BIT];
            sl_r <= cmd[grm_pkg::SL_BIT];
            page_r <= cmd[grm_pkg::H_BIT];
         end
      end
   end

   // Address counter; glyph bit 6 never moves on set-glyph-address
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cg_addr_r <= '0;
         dd_addr_r <= '0;
         sel_cg_r <= 1'h0;
      end else if (state_r == grm_pkg::ST_CLEAR) begin
         dd_addr_r <= '0;
         sel_cg_r <= 1'h0;
      end else if (instr_go && !page_r) begin
         if (cmd_cls == grm_pkg::CMD_HOME) begin
            dd_addr_r <= '0;
            sel_cg_r <= 1'h0;
         end
         if (cmd_cls == grm_pkg::CMD_SETCG) begin
            cg_addr_r[AW-2:0] <= cmd[AW-2:0];
            sel_cg_r <= 1'h1;
         end
         if (cmd_cls == grm_pkg::CMD_SETDD) begin
            dd_addr_r <= cmd[AW-1:0];
            sel_cg_r <= 1'h0;
            if (dd_in_range(cmd[AW-1:0], lines_r)) begin
               cg_addr_r[AW-1] <= cmd[AW-1];
            end
         end
      end else if (data_go || dread_go) begin
         if (sel_cg_r) begin
            cg_addr_r <= step_addr(cg_addr_r, id_r);
         end else begin
            dd_addr_r <= step_addr(dd_addr_r, id_r);
         end
      end
   end

   // Code RAM; the clear sweep fills spaces in the first 128 clear cycles
   always_ff @(posedge hclk) begin
      if (state_r == grm_pkg::ST_CLEAR && cnt_r < DD_DEPTH_CNT) begin
         character_code_ram[cnt_r[AW-1:0]] <= grm_pkg::SPACE_CODE;
      end else if (data_go && !sel_cg_r) begin
         character_code_ram[dd_addr_r] <= cmd;
      end
   end

   // Pattern fetch selection written by software
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         px_sel_r <= '{cur: 1'h0, row: '0, code: grm_pkg::SPACE_CODE}; // A ROM code, not unloaded glyph RAM
      end else if (wr_pend_r && addr_r == grm_pkg::REG_PXSEL) begin
         px_sel_r <= grm_pkg::grm_pxsel_s'(hwdata[$bits(grm_pkg::grm_pxsel_s)-1:0]);
      end
   end

   grm_glyph_ram u_glyph (
      .clk(hclk),
      .rst_n(hresetn),
      .wr_en(data_go && sel_cg_r),
      .wr_addr(cg_addr_r),
      .wr_data(cmd),
      .rd_addr(cg_addr_r),
      .rd_data(gl_rd_data),
      .code(px_sel_r.code),
      .row(px_sel_r.row),
      .cursor_here(px_cursor),
      .pixels(gl_pixels),
      .hit(gl_hit)
   );

   // Read mux; unmapped and write-only words read as zero
   always_comb begin
      rdata_nxt = '0;
      case (addr_r)
         grm_pkg::REG_DATA: begin
            if (dread_go) begin
               rdata_nxt[7:0] = dread_byte;
            end
         end
         grm_pkg::REG_STATUS: rdata_nxt[AW:0] = {busy_indicator, ac};
         grm_pkg::REG_CONFIG: rdata_nxt[$bits(cfg)-1:0] = cfg;
         grm_pkg::REG_PXSEL: rdata_nxt[$bits(px_sel_r)-1:0] = px_sel_r;
         grm_pkg::REG_PXROW: rdata_nxt[grm_pkg::GR_COLS:0] = {gl_hit, gl_pixels & {grm_pkg::GR_COLS{display_enable}}};
         default: rdata_nxt = '0;
      endcase
   end

   // Bus slave: writes zero wait, reads one wait so hrdata is a flop
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_r <= 1'h0;
         rd_pend_r <= 1'h0;
         addr_r <= '0;
         hreadyout <= 1'h1;
         hrdata <= '0;
         hresp <= 1'h0;
      end else begin
         wr_pend_r <= accept && hwrite && hsize == grm_pkg::HSIZE_WORD;
         rd_pend_r <= accept && !hwrite;
         if (accept) begin
            addr_r <= {haddr[grm_pkg::ADDR_W-1:2], 2'h0};
         end
         hreadyout <= !(accept && !hwrite);
         if (rd_pend_r) begin
            hrdata <= rdata_nxt;
         end
         hresp <= 1'h0;
      end
   end

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   sequence clr_start;
      state_r == grm_pkg::ST_CLEAR && cnt_r == '0;
   endsequence
   sequence clr_body;
      ##164 (state_r == grm_pkg::ST_CLEAR) ##1 (state_r != grm_pkg::ST_CLEAR);
   endsequence

   clear_length_a: assert property (clr_start |-> clr_body)
      else $error("clear step not 165 cycles");
   busy_tracks_a: assert property (busy_indicator == (state_r != grm_pkg::ST_IDLE))
      else $error("busy indicator out of step with sequencer");
   reset_display_a: assert property (from_rst_r |-> !display_enable && !cur_r && !blink_r)
      else $error("display bits not off during init");
   reset_modes_a: assert property (from_rst_r |-> id_r && !shift_r && dl_r && !lines_r && !page_r && !sl_r)
      else $error("mode bits not at reset values during init");
   serial_idle_a: assert property (from_rst_r |=> ser_state_r == grm_pkg::SER_IDLE)
      else $error("serial state not idle during init");
   busy_ignore_a: assert property ((wr_pend_r && state_r != grm_pkg::ST_IDLE) |=> $stable(cfg) && !$rose(sel_cg_r))
      else $error("instruction taken while busy");
   status_read_a: assert property ((accept && !hwrite && haddr == grm_pkg::REG_STATUS)
      |-> ##1 !hreadyout ##1 (hreadyout && hrdata[AW:0] == {$past(busy_indicator), $past(ac)}))
      else $error("status read wrong");
   status_cg_a: assert property ((rd_pend_r && addr_r == grm_pkg::REG_STATUS && sel_cg_r)
      |=> hrdata[AW-1:0] == $past(cg_addr_r))
      else $error("status lost glyph address bits");
   cg_keep_bit6_a: assert property ((instr_go && !page_r && cmd_cls == grm_pkg::CMD_SETCG)
      |=> cg_addr_r[AW-1] == $past(cg_addr_r[AW-1]) && cg_addr_r[AW-2:0] == $past(cmd[AW-2:0]))
      else $error("set glyph address touched bit 6");
   cg_carry_a: assert property ((data_go && sel_cg_r && id_r && cg_addr_r == 7'h3F) |=> cg_addr_r == 7'h40)
      else $error("glyph address carry lost");
   dd_bit6_a: assert property ((instr_go && !page_r && cmd_cls == grm_pkg::CMD_SETDD
      && dd_in_range(cmd[AW-1:0], lines_r)) |=> cg_addr_r[AW-1] == $past(cmd[AW-1]))
      else $error("code address command did not set bit 6");

endmodule
`default_nettype wire

/* tb/grm_host_model.sv */
// Host processor model: single-word AHB-Lite master for the glyph controller.
// Assumes one slave whose hreadyout is fed back as hready.
`timescale 1ns/1ps
`default_nettype none
module grm_host_model (
   input wire logic hclk, // Clock
   input wire logic hready, // Bus ready
   input wire logic [31:0] hrdata, // Read data
   output logic hsel, // Slave select
   output logic [grm_pkg::ADDR_W-1:0] haddr, // Byte address
   output logic [1:0] htrans, // Transfer type
   output logic hwrite, // Write when high
   output logic [2:0] hsize, // Transfer size
   output logic [31:0] hwdata // Write data
);
   // Bus idle at time zero
   initial begin
      hsel = 1'h0;
      haddr = 8'h00;
      htrans = 2'h0;
      hwrite = 1'h0;
      hsize = 3'h2;
      hwdata = 32'h0;
   end

   // One transfer; waits as long as the slave stalls, never a fixed count
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
      @(posedge hclk);
      hsel <= 1'h1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= wr;
      hsize <= grm_pkg::HSIZE_WORD;
      do @(posedge hclk); while (hready !== 1'h1);
      htrans <= 2'h0;
      hsel <= 1'h0;
      hwdata <= wd;
      do @(posedge hclk); while (hready !== 1'h1);
      rd = hrdata;
      // Stale data would hide a slave sampling too late
      hwdata <= ~wd;
   endtask
endmodule
`default_nettype wire

/* tb/grm_glyph_ctrl_test.sv */
// Self-checking bench for the glyph controller: reset state, busy timing,
// glyph address handling and pattern fetch, through register accesses and the busy and display outputs.
// Assumes the host model in tb/ and the package in inc/.
`timescale 1ns/1ps
`default_nettype none
module grm_glyph_ctrl_test;
   localparam int INIT = 400;
   logic hclk = 1'h0;
   logic hresetn = 1'h0;
   logic hsel, hwrite, hreadyout, hresp, busy_indicator, display_enable;
   logic [7:0] haddr;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] hwdata, hrdata, rd;
   int n_mismatch = 0;
   int n_tests = 0;
   int cyc = 0;

   // Clock of 4 ns
   always #2 hclk = ~hclk;

   grm_host_model host (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
   grm_glyph_ctrl #(.INIT_CYCLES(INIT)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .busy_indicator(busy_indicator), .display_enable(display_enable));

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic test_done();
      $display("Counts: %0d mismatches in %0d comparisons", n_mismatch, n_tests);
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // Hang guard, more than ten times the expected run length
   always @(posedge hclk) begin
      cyc = cyc + 1;
      if (cyc == 30000) begin
         n_mismatch++;
         test_done();
      end
   end

   // Poll status until idle; last status word stays in rd
   task automatic wait_ready();
      int n;
      n = 0;
      do begin
         host.xfer(1'h0, grm_pkg::REG_STATUS, 32'h0, rd);
         n++;
      end while (rd[7] !== 1'h0 && n < 300);
      if (n >= 300) begin
         n_mismatch++;
         $display("mismatch at %0t: busy never cleared", $time);
      end
   endtask

   // Instruction or data byte, only once the controller is idle
   task automatic cmd(input logic [7:0] a, input logic [31:0] d);
      wait_ready();
      host.xfer(1'h1, a, d, rd);
   endtask

   // Select code, row and cursor, then read the fetched pixel row
   task automatic pix(input logic [7:0] code, input logic [2:0] row, input logic cur, input logic [5:0] e);
      host.xfer(1'h1, grm_pkg::REG_PXSEL, {20'h0, cur, row, code}, rd);
      host.xfer(1'h0, grm_pkg::REG_PXROW, 32'h0, rd);
      check({26'h0, rd[5:0]}, {26'h0, e});
   endtask

   initial begin
      int span;
      logic [4:0] pat;
      repeat (12) @(posedge hclk);
      check({30'h0, busy_indicator, display_enable}, 32'h2);
      hresetn <= 1'h1;
      span = cyc;
      // Display-on sent while initialising must be dropped
      host.xfer(1'h1, grm_pkg::REG_INSTR, 32'h0C, rd);
      host.xfer(1'h0, grm_pkg::REG_STATUS, 32'h0, rd);
      check({31'h0, rd[7]}, 32'h1);
      check({31'h0, display_enable}, 32'h0);
      host.xfer(1'h0, grm_pkg::REG_CONFIG, 32'h0, rd);
      check({9'h0, rd[22:0]}, 32'h0008_0021);
      while (busy_indicator !== 1'h0 && cyc - span < 1000) @(posedge hclk);
      span = cyc - span;
      check({31'h0, span >= INIT - 3 && span <= INIT + 3}, 32'h1);
      host.xfer(1'h0, 8'h18, 32'h0, rd);
      check(rd, 32'h0);
      // Display and cursor on; low six glyph address bits only
      cmd(grm_pkg::REG_INSTR, 32'h0E);
      cmd(grm_pkg::REG_INSTR, 32'h7F);
      check({31'h0, display_enable}, 32'h1);
      wait_ready();
      check({24'h0, rd[7:0]}, 32'h3F);
      cmd(grm_pkg::REG_DATA, 32'h1F);
      wait_ready();
      check({24'h0, rd[7:0]}, 32'h40);
      // Code address in range copies its bit 6, out of range leaves it
      cmd(grm_pkg::REG_INSTR, 32'h85);
      cmd(grm_pkg::REG_INSTR, 32'h7A);
      wait_ready();
      check({24'h0, rd[7:0]}, 32'h3A);
      cmd(grm_pkg::REG_INSTR, 32'hD5);
      cmd(grm_pkg::REG_INSTR, 32'h7A);
      wait_ready();
      check({24'h0, rd[7:0]}, 32'h3A);
      cmd(grm_pkg::REG_INSTR, 32'hC5);
      cmd(grm_pkg::REG_INSTR, 32'h7A);
      wait_ready();
      check({24'h0, rd[7:0]}, 32'h7A);
      // Glyph for code 1, upper data bits set to prove they are ignored
      cmd(grm_pkg::REG_INSTR, 32'h80);
      cmd(grm_pkg::REG_INSTR, 32'h48);
      for (int r = 0; r < 8; r++) begin
         cmd(grm_pkg::REG_DATA, {24'h0, 3'h5, 5'(r * 3 + 1)});
      end
      // Read back the first row word; the counter steps after the read
      cmd(grm_pkg::REG_INSTR, 32'h48);
      wait_ready();
      host.xfer(1'h0, grm_pkg::REG_DATA, 32'h0, rd);
      check(rd, 32'h0000_00A1);
      check({31'h0, hresp}, 32'h0);
      wait_ready();
      check({24'h0, rd[7:0]}, 32'h09);
      wait_ready();
      for (int r = 0; r < 8; r++) begin
         pat = 5'(r * 3 + 1);
         pix(8'h01, 3'(r), 1'h0, {1'h1, pat});
      end
      pix(8'h01, 3'h3, 1'h1, 6'h2A);
      pix(8'h01, 3'h7, 1'h1, 6'h3F);
      pix(8'h11, 3'h0, 1'h0, 6'h00);
      pix(8'hF1, 3'h1, 1'h0, 6'h00);
      cmd(grm_pkg::REG_INSTR, 32'h0C);
      wait_ready();
      pix(8'h01, 3'h7, 1'h1, 6'h36);
      // Clear command runs the same 165-cycle sweep and homes the counter
      cmd(grm_pkg::REG_INSTR, 32'h01);
      span = cyc;
      wait_ready();
      check({31'h0, cyc - span >= 165 && cyc - span <= 175}, 32'h1);
      check({24'h0, rd[7:0]}, 32'h00);
      // Second reset in mid-run restores the off state
      @(posedge hclk);
      hresetn <= 1'h0;
      repeat (2) @(posedge hclk);
      check({30'h0, busy_indicator, display_enable}, 32'h2);
      hresetn <= 1'h1;
      host.xfer(1'h0, grm_pkg::REG_STATUS, 32'h0, rd);
      check({24'h0, rd[7:0]}, 32'h80);
      host.xfer(1'h0, grm_pkg::REG_CONFIG, 32'h0, rd);
      check(rd, 32'h0008_0021);
      test_done();
   end
endmodule
`default_nettype wire
